// ===== logic/tmsc_pkg.sv
package tmsc_pkg;
  localparam int KEYS = 24;
  localparam int KW = 5;
  localparam int AW = 8;
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int MS_W = 15;
  localparam int SYNC_WAIT_MS = 100;
  localparam int UNIT_MS = 100;
  localparam logic [7:0] SHIFT_AWAKE_SET = 8'h19;
  localparam int MAX_PULSES = 64;
  localparam int PULSE_STEP = 16;
  localparam int PH_W = 7;
  localparam int SLEEP_MS [8] = '{16, 32, 64, 125, 250, 500, 1000, 2000};

  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_AWAKE = 8'h04;
  localparam logic [AW-1:0] A_DRIFT = 8'h08;
  localparam logic [AW-1:0] A_STATUS = 8'h0c;
  localparam logic [AW-1:0] A_KEYS = 8'h10;
  localparam logic [AW-1:0] A_CFG = 8'h40;

  localparam int C_RUN = 0;
  localparam int C_LOWPWR = 1;
  localparam int C_LOCK = 2;
  localparam int C_SHIFT = 3;
  localparam int C_SLEEP_LO = 4;
  localparam logic [6:0] CTRL_RST = 7'h31;

  localparam int F_WAKE = 3;
  localparam int F_BL_LO = 4;
  localparam int F_AKS = 6;
  localparam int F_PROBE = 7;
  localparam logic [7:0] CFG_RST = 8'h28;
  localparam logic [7:0] AWAKE_RST = 8'h19;
  localparam logic [7:0] DHT_RST = 8'h0a;

  localparam int S_CHANGE = 0;
  localparam int S_FAST = 1;
  localparam int S_HOLD = 2;
  localparam int S_SLEEP = 3;
  localparam int S_SYNC = 4;

  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SLEEP, ST_SYNC, ST_BURST} tmsc_state_t;

  typedef struct packed {
    logic [KW-1:0] key;
    logic [15:0] dev;
    logic detect;
  } tmsc_meas_t;

  typedef struct packed {
    logic drive_pulse;
    logic recv_en;
    logic [KW-1:0] key;
    logic probe_trigger;
    logic burst_done;
  } tmsc_burst_t;
endpackage : tmsc_pkg

// ===== logic/tmsc_scan_ctrl.sv
`timescale 1ns/1ps
module tmsc_scan_ctrl #(
  parameter int TICK_CYCLES = tmsc_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tmsc_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tmsc_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tmsc_pkg::tmsc_meas_t meas,
  input wire logic meas_valid,
  input wire logic line_sync_in,
  output tmsc_pkg::tmsc_burst_t burst,
  output logic [tmsc_pkg::KEYS-1:0] key_state,
  output logic change_out,
  output logic fast_mode,
  output logic drift_hold,
  output logic sleeping
);
  localparam logic [tmsc_pkg::MS_W-1:0] TICK_LAST = tmsc_pkg::MS_W'(TICK_CYCLES - 1);
  localparam logic [tmsc_pkg::MS_W-1:0] UNIT = tmsc_pkg::MS_W'(tmsc_pkg::UNIT_MS);

  typedef struct packed {
    tmsc_pkg::tmsc_state_t state;
    logic [tmsc_pkg::MS_W-1:0] tick_cnt;
    logic [tmsc_pkg::MS_W-1:0] wait_ms;
    logic [tmsc_pkg::MS_W-1:0] awake_ms;
    logic [tmsc_pkg::MS_W-1:0] hold_ms;
    logic [tmsc_pkg::PH_W-1:0] phase;
    logic sync1;
    logic sync2;
    logic sync3;
    logic fast;
    logic change_flag;
    logic [6:0] ctrl;
    logic [7:0] awake_set;
    logic [7:0] dht_set;
    logic [tmsc_pkg::KEYS-1:0][7:0] cfg;
    logic [tmsc_pkg::KEYS-1:0][15:0] dev;
    logic [tmsc_pkg::KEYS-1:0] keys;
    logic aw_got;
    logic w_got;
    logic [tmsc_pkg::AW-1:0] awaddr;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    tmsc_pkg::tmsc_burst_t burst;
  } tmsc_regs_t;

  tmsc_regs_t st_r;
  tmsc_regs_t st_nxt;
  logic [tmsc_pkg::KEYS-1:0] beats;

  // Suppression compares raw stored deviations of the other keys that have F_AKS set
  genvar gj;
  generate
    for (gj = 0; gj < tmsc_pkg::KEYS; gj++) begin : g_cmp
      assign beats[gj] = st_r.cfg[gj][tmsc_pkg::F_AKS] &&
                         (tmsc_pkg::KW'(gj) != meas.key) &&
                         ($signed(st_r.dev[gj]) < $signed(meas.dev));
    end
  endgenerate

  function automatic logic [tmsc_pkg::PH_W-1:0] last_phase(input logic [1:0] code);
    logic [tmsc_pkg::PH_W-1:0] pulses;
    // Two clocks per transfer cycle: drive high, then drive low
    pulses = tmsc_pkg::PH_W'((int'(code) + 1) * tmsc_pkg::PULSE_STEP);
    return tmsc_pkg::PH_W'({pulses, 1'b0} - 8'h01);
  endfunction : last_phase

  function automatic logic [tmsc_pkg::MS_W-1:0] sleep_ms(input logic [2:0] idx);
    return tmsc_pkg::MS_W'(tmsc_pkg::SLEEP_MS[idx]);
  endfunction : sleep_ms

  function automatic logic map_ok(input logic [tmsc_pkg::AW-1:0] a);
    return (a == tmsc_pkg::A_CTRL) || (a == tmsc_pkg::A_AWAKE) ||
           (a == tmsc_pkg::A_DRIFT) || (a == tmsc_pkg::A_STATUS) ||
           (a == tmsc_pkg::A_KEYS) ||
           ((a >= tmsc_pkg::A_CFG) && (a[1:0] == 2'h0) &&
            (a < tmsc_pkg::AW'(int'(tmsc_pkg::A_CFG) + 4 * tmsc_pkg::KEYS)));
  endfunction : map_ok

  always_comb begin
    logic tick;
    logic fall;
    logic [tmsc_pkg::AW-1:0] rel;
    logic [tmsc_pkg::KW-1:0] idx;
    logic newst;
    logic changed;
    logic waker;
    logic [7:0] aw_eff;
    logic start_scan;
    st_nxt = st_r;
    tick = (st_r.tick_cnt == TICK_LAST);
    fall = st_r.sync3 && !st_r.sync2;
    rel = '0;
    idx = '0;
    newst = 1'b0;
    changed = 1'b0;
    waker = 1'b0;
    start_scan = 1'b0;
    aw_eff = st_r.ctrl[tmsc_pkg::C_SHIFT] ? tmsc_pkg::SHIFT_AWAKE_SET : st_r.awake_set;
    st_nxt.burst.burst_done = 1'b0;
    st_nxt.tick_cnt = tick ? '0 : tmsc_pkg::MS_W'(st_r.tick_cnt + 1'b1);
    // Two flops against metastability; the third only keeps the edge history
    st_nxt.sync1 = line_sync_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;

    // Register bus: write address and data may arrive in either order
    if (s_axi_awvalid && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wbyte = s_axi_wdata[7:0];
      st_nxt.wlane0 = s_axi_wstrb[0];
    end
    // Both halves held: commit now and answer next cycle, one write in flight
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = map_ok(st_r.awaddr) ? tmsc_pkg::RESP_OK : tmsc_pkg::RESP_ERR;
      if (st_r.wlane0) begin
        rel = tmsc_pkg::AW'(st_r.awaddr - tmsc_pkg::A_CFG);
        if (st_r.awaddr == tmsc_pkg::A_CTRL) begin
          st_nxt.ctrl = st_r.wbyte[6:0];
        end else if (st_r.awaddr == tmsc_pkg::A_AWAKE) begin
          // Zero is not legal for the host; here it would end fast mode a cycle later
          st_nxt.awake_set = st_r.wbyte;
        end else if (st_r.awaddr == tmsc_pkg::A_DRIFT) begin
          st_nxt.dht_set = st_r.wbyte;
        end else if (st_r.awaddr == tmsc_pkg::A_STATUS) begin
          if (st_r.wbyte[tmsc_pkg::S_CHANGE]) begin
            st_nxt.change_flag = 1'b0;
          end
        end else if (map_ok(st_r.awaddr) && st_r.awaddr >= tmsc_pkg::A_CFG) begin
          st_nxt.cfg[rel[tmsc_pkg::KW+1:2]] = st_r.wbyte;
        end
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = map_ok(s_axi_araddr) ? tmsc_pkg::RESP_OK : tmsc_pkg::RESP_ERR;
      st_nxt.rdata = '0;
      rel = tmsc_pkg::AW'(s_axi_araddr - tmsc_pkg::A_CFG);
      case (s_axi_araddr)
        tmsc_pkg::A_CTRL: st_nxt.rdata = {25'h0, st_r.ctrl};
        tmsc_pkg::A_AWAKE: st_nxt.rdata = {24'h0, st_r.awake_set};
        tmsc_pkg::A_DRIFT: st_nxt.rdata = {24'h0, st_r.dht_set};
        tmsc_pkg::A_STATUS: begin
          st_nxt.rdata[tmsc_pkg::S_CHANGE] = st_r.change_flag;
          st_nxt.rdata[tmsc_pkg::S_FAST] = st_r.fast;
          st_nxt.rdata[tmsc_pkg::S_HOLD] = (st_r.hold_ms != '0);
          st_nxt.rdata[tmsc_pkg::S_SLEEP] = (st_r.state == tmsc_pkg::ST_SLEEP);
          st_nxt.rdata[tmsc_pkg::S_SYNC] = (st_r.state == tmsc_pkg::ST_SYNC);
        end
        tmsc_pkg::A_KEYS: st_nxt.rdata = 32'(st_r.keys);
        default: begin
          if (map_ok(s_axi_araddr)) begin
            st_nxt.rdata = {24'h0, st_r.cfg[rel[tmsc_pkg::KW+1:2]]};
          end
        end
      endcase
    end

    // Timers count whole milliseconds off the shared tick
    if (tick && st_r.wait_ms != '0) begin
      st_nxt.wait_ms = st_r.wait_ms - 1'b1;
    end
    if (tick && st_r.hold_ms != '0) begin
      st_nxt.hold_ms = st_r.hold_ms - 1'b1;
    end
    if (tick && st_r.awake_ms != '0) begin
      st_nxt.awake_ms = st_r.awake_ms - 1'b1;
    end
    if (st_r.fast && st_r.awake_ms == '0) begin
      st_nxt.fast = 1'b0;
    end

    // Measurement from the front end, one per burst
    // Comes after the bus write so an event in the clearing cycle still sets the flag
    if (meas_valid && int'(meas.key) < tmsc_pkg::KEYS) begin
      idx = meas.key;
      // Other keys are judged on their latest stored deviation, at most one scan old
      newst = meas.detect && !(st_r.cfg[idx][tmsc_pkg::F_AKS] && (|beats));
      changed = (newst != st_r.keys[idx]);
      waker = st_r.cfg[idx][tmsc_pkg::F_WAKE] || st_r.ctrl[tmsc_pkg::C_SHIFT];
      st_nxt.dev[idx] = meas.dev;
      st_nxt.keys[idx] = newst;
      if (newst && !st_r.keys[idx]) begin
        st_nxt.hold_ms = tmsc_pkg::MS_W'(st_r.dht_set) * UNIT;
      end
      if (changed && (waker || st_r.fast)) begin
        st_nxt.fast = 1'b1;
        st_nxt.awake_ms = tmsc_pkg::MS_W'(aw_eff) * UNIT;
      end
      if (changed && waker && !st_r.ctrl[tmsc_pkg::C_SHIFT]) begin
        st_nxt.change_flag = 1'b1;
      end
    end

    case (st_r.state)
      tmsc_pkg::ST_IDLE: begin
        start_scan = st_r.ctrl[tmsc_pkg::C_RUN];
      end
      tmsc_pkg::ST_SLEEP: begin
        // A wake change during sleep cuts the sleep short
        if (st_r.wait_ms == '0 || st_nxt.fast) begin
          start_scan = 1'b1;
        end
      end
      tmsc_pkg::ST_SYNC: begin
        if (fall || st_r.wait_ms == '0) begin
          st_nxt.state = tmsc_pkg::ST_BURST;
          st_nxt.burst.key = '0;
          st_nxt.phase = '0;
        end
      end
      tmsc_pkg::ST_BURST: begin
        st_nxt.phase = tmsc_pkg::PH_W'(st_r.phase + 1'b1);
        // Phase counts clocks, two per transfer cycle
        if (st_r.phase == last_phase(st_r.cfg[st_r.burst.key][tmsc_pkg::F_BL_LO +: 2])) begin
          st_nxt.burst.burst_done = 1'b1;
          st_nxt.phase = '0;
          if (int'(st_r.burst.key) == tmsc_pkg::KEYS - 1) begin
            if (st_r.ctrl[tmsc_pkg::C_LOWPWR] && !st_nxt.fast) begin
              st_nxt.state = tmsc_pkg::ST_SLEEP;
              st_nxt.wait_ms = sleep_ms(st_r.ctrl[tmsc_pkg::C_SLEEP_LO +: 3]);
            end else begin
              start_scan = 1'b1;
            end
          end else begin
            st_nxt.burst.key = tmsc_pkg::KW'(st_r.burst.key + 1'b1);
          end
        end
      end
      default: st_nxt.state = tmsc_pkg::ST_IDLE;
    endcase

    // Lock wait only ahead of key 0, so at most once per full scan
    if (start_scan) begin
      st_nxt.phase = '0;
      st_nxt.burst.key = '0;
      if (st_r.ctrl[tmsc_pkg::C_LOCK]) begin
        st_nxt.state = tmsc_pkg::ST_SYNC;
        st_nxt.wait_ms = tmsc_pkg::MS_W'(tmsc_pkg::SYNC_WAIT_MS);
      end else begin
        st_nxt.state = tmsc_pkg::ST_BURST;
      end
    end
    // Clearing run stops at once, so a burst in progress may be cut short
    if (!st_r.ctrl[tmsc_pkg::C_RUN]) begin
      st_nxt.state = tmsc_pkg::ST_IDLE;
    end

    st_nxt.burst.recv_en = (st_nxt.state == tmsc_pkg::ST_BURST);
    st_nxt.burst.drive_pulse = st_nxt.burst.recv_en && !st_nxt.phase[0];
    st_nxt.burst.probe_trigger = st_nxt.burst.recv_en &&
                                 st_r.cfg[st_nxt.burst.key][tmsc_pkg::F_PROBE];
  end

  // Synchronous reset loads constants only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.state <= tmsc_pkg::ST_IDLE;
      st_r.ctrl <= tmsc_pkg::CTRL_RST;
      st_r.awake_set <= tmsc_pkg::AWAKE_RST;
      st_r.dht_set <= tmsc_pkg::DHT_RST;
      st_r.cfg <= {tmsc_pkg::KEYS{tmsc_pkg::CFG_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Readies decode registered state, so no bus input reaches an output directly
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign burst = st_r.burst;
  assign key_state = st_r.keys;
  assign change_out = st_r.change_flag;
  assign fast_mode = st_r.fast;
  // Status levels decode counters and state rather than keeping extra flops
  assign drift_hold = (st_r.hold_ms != '0);
  assign sleeping = (st_r.state == tmsc_pkg::ST_SLEEP);
endmodule : tmsc_scan_ctrl

// ===== tb/tmsc_scan_ctrl_sva.sv
`timescale 1ns/1ps
module tmsc_scan_ctrl_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire tmsc_pkg::tmsc_burst_t burst,
  input wire logic change_out,
  input wire logic fast_mode
);
  // Restarts at each burst end, since the next key may follow without a gap
  logic [7:0] run_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || !burst.recv_en || burst.burst_done) run_r <= 8'h00;
    else run_r <= run_r + 8'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_pulse;
    burst.drive_pulse ##1 !burst.drive_pulse;
  endsequence
  pulse_in_burst_a: assert property (burst.drive_pulse |-> burst.recv_en)
    else $error("drive pulse outside burst");
  pulse_single_a: assert property (burst.drive_pulse |-> s_pulse)
    else $error("drive pulse longer than one cycle");
  probe_in_burst_a: assert property (burst.probe_trigger |-> burst.recv_en)
    else $error("probe pulse outside burst");
  burst_max_a: assert property (run_r <= 8'h80)
    else $error("burst longer than 64 transfers");
  done_single_a: assert property (burst.burst_done |=> !burst.burst_done)
    else $error("burst done longer than one cycle");
  key_range_a: assert property (burst.recv_en |-> burst.key < 5'h18)
    else $error("burst of a key beyond the matrix");
  fast_change_a: assert property ($rose(fast_mode) |-> change_out)
    else $error("fast mode without change output");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
endmodule : tmsc_scan_ctrl_sva

// ===== tb/tmsc_front_model.sv
`timescale 1ns/1ps
module tmsc_front_model (
  input wire logic aclk,
  input wire tmsc_pkg::tmsc_burst_t burst,
  input wire logic [15:0] dev_tab [24],
  input wire logic [23:0] det_tab,
  output tmsc_pkg::tmsc_meas_t meas,
  output logic meas_valid
);
  logic [4:0] key_r = 5'h00;
  // Result lands one cycle after burst_done; between results the bus toggles
  always @(posedge aclk) begin
    if (burst.recv_en) key_r <= burst.key;
    meas_valid <= burst.burst_done;
    if (burst.burst_done) begin
      meas.key <= key_r;
      meas.dev <= dev_tab[key_r];
      meas.detect <= det_tab[key_r];
    end else meas <= ~meas;
  end
endmodule : tmsc_front_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, meas_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  tmsc_pkg::tmsc_meas_t meas;
  tmsc_pkg::tmsc_burst_t burst;
  logic [23:0] key_state;
  logic change_out, fast_mode, drift_hold, sleeping;
  logic sync_in = 1'b1;
  logic [15:0] dev_tab [24];
  logic [23:0] det_tab = 24'h0;
  logic [23:0] probe_en = 24'h0;
  logic [1:0] code_r [24];
  logic chk = 1'b0;
  int len_a [24];
  int pul_a [24];
  int err_count = 0;
  int check_count = 0;
  int seed = 32'h873497e2;
  int g;
  logic [1:0] bexp_q [$];
  logic [33:0] exp_q [$];
  tmsc_scan_ctrl #(.TICK_CYCLES(10)) u_tmsc_scan_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .meas(meas), .meas_valid(meas_valid), .line_sync_in(sync_in), .burst(burst),
    .key_state(key_state), .change_out(change_out), .fast_mode(fast_mode),
    .drift_hold(drift_hold), .sleeping(sleeping));
  tmsc_front_model u_tmsc_front_model (.aclk(aclk), .burst(burst), .dev_tab(dev_tab),
    .det_tab(det_tab), .meas(meas), .meas_valid(meas_valid));
  initial begin
    forever #20 aclk = ~aclk;
  end
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic hang();
    err_count++;
    $display("CHECK FAILED %0t wait ran out", $time);
    wrap_up();
  endtask : hang
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    bexp_q.push_back(er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 200) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    exp_q.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 200) hang();
  endtask : rd
  // One whole scan is counted between two sightings of the last key; key 23 is partial
  task automatic scan_lens();
    int n;
    for (n = 0; n < 9000 && burst.key != 5'd23; n++) @(posedge aclk);
    for (int k = 0; k < 24; k++) len_a[k] = 0;
    for (int k = 0; k < 24; k++) pul_a[k] = 0;
    chk <= 1'b1;
    for (n = 0; n < 9000 && burst.key == 5'd23; n++) @(posedge aclk);
    for (n = 0; n < 9000 && burst.key != 5'd23; n++) @(posedge aclk);
    chk <= 1'b0;
    if (n == 9000) hang();
    for (int k = 0; k < 23; k++) begin
      check(len_a[k] == (int'(code_r[k]) + 1) * 32, "burst length");
      check(pul_a[k] == (int'(code_r[k]) + 1) * 16, "drive pulses");
    end
  endtask : scan_lens
  task automatic gap(input int fall_at);
    int n;
    for (n = 0; n < 9000 && !(burst.recv_en && burst.key == 5'd23); n++) @(posedge aclk);
    for (n = 0; n < 9000 && burst.recv_en; n++) @(posedge aclk);
    for (g = 0; g < 3000 && !burst.recv_en; g++) begin
      @(posedge aclk);
      sync_in <= (g < fall_at);
    end
    sync_in <= 1'b1;
  endtask : gap
  always @(posedge aclk) begin
    if (bvalid && bready) check(bresp === bexp_q.pop_front(), "write response");
    if (rvalid && rready) check({rresp, rdata} === exp_q.pop_front(), "read data");
    if (chk && burst.recv_en) len_a[burst.key] += 1;
    if (chk && burst.drive_pulse) pul_a[burst.key] += 1;
    if (chk) check(burst.probe_trigger === (burst.recv_en & probe_en[burst.key]), "probe");
  end
  initial begin
    #4000000;
    hang();
  end
  initial begin
    for (int k = 0; k < 24; k++) dev_tab[k] = 16'h0000;
    for (int k = 0; k < 24; k++) code_r[k] = 2'h2;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(tmsc_pkg::A_CTRL, 32'h31, tmsc_pkg::RESP_OK);
    rd(tmsc_pkg::A_AWAKE, 32'h19, tmsc_pkg::RESP_OK);
    rd(tmsc_pkg::A_DRIFT, 32'h0a, tmsc_pkg::RESP_OK);
    for (int k = 0; k < 24; k++) rd(tmsc_pkg::A_CFG + 8'(k * 4), 32'h28, 2'h0);
    rd(8'hfc, 32'h0, tmsc_pkg::RESP_ERR);
    wr(8'hfc, 8'hff, tmsc_pkg::RESP_ERR);
    scan_lens();
    dev_tab[2] = 16'hffce;
    dev_tab[7] = 16'hffb0;
    dev_tab[9] = 16'hff9c;
    det_tab = 24'h000284;
    for (int k = 0; k < 24; k++) begin
      code_r[k] = 2'($random(seed));
      probe_en[k] = 1'($random(seed));
      wr(tmsc_pkg::A_CFG + 8'(k * 4), {probe_en[k], 1'b0, code_r[k], 4'h8}, 2'h0);
    end
    scan_lens();
    rd(tmsc_pkg::A_KEYS, 32'h284, tmsc_pkg::RESP_OK);
    rd(tmsc_pkg::A_STATUS, 32'h07, tmsc_pkg::RESP_OK);
    check(key_state === 24'h000284, "key state output");
    check(change_out && fast_mode && drift_hold && !sleeping, "status outputs");
    code_r[2] = 2'h0;
    code_r[7] = 2'h0;
    probe_en[2] = 1'b0;
    probe_en[7] = 1'b0;
    wr(tmsc_pkg::A_CFG + 8'h08, 8'h48, tmsc_pkg::RESP_OK);
    wr(tmsc_pkg::A_CFG + 8'h1c, 8'h48, tmsc_pkg::RESP_OK);
    scan_lens();
    rd(tmsc_pkg::A_KEYS, 32'h280, tmsc_pkg::RESP_OK);
    check(key_state === 24'h000280, "suppressed key state");
    wr(tmsc_pkg::A_CTRL, 8'h35, tmsc_pkg::RESP_OK);
    gap(5000);
    gap(5000);
    check(g >= 980 && g <= 1020, "scan start without sync edge");
    gap(200);
    check(g >= 200 && g <= 240, "scan start after sync edge");
    wr(tmsc_pkg::A_CTRL, 8'h13, tmsc_pkg::RESP_OK);
    for (g = 0; g < 45000 && !sleeping; g++) @(posedge aclk);
    if (g == 45000) hang();
    check(fast_mode === 1'b0, "fast mode outlived awake timeout");
    for (g = 0; g < 1000 && sleeping; g++) @(posedge aclk);
    check(g >= 300 && g <= 330, "sleep length");
    wr(tmsc_pkg::A_AWAKE, 8'h0a, tmsc_pkg::RESP_OK);
    rd(tmsc_pkg::A_AWAKE, 32'h0a, tmsc_pkg::RESP_OK);
    det_tab <= 24'h000281;
    scan_lens();
    check(key_state === 24'h000281, "wake key state");
    check(change_out === 1'b1, "wake change output");
    check(fast_mode === 1'b1, "wake fast mode");
    check(sleeping === 1'b0, "asleep in fast mode");
    check(drift_hold === 1'b1, "drift hold after detection");
    wr(tmsc_pkg::A_STATUS, 8'h01, tmsc_pkg::RESP_OK);
    check(change_out === 1'b0, "change output not cleared");
    wr(tmsc_pkg::A_CTRL, 8'h09, tmsc_pkg::RESP_OK);
    det_tab <= 24'h000280;
    scan_lens();
    check(key_state === 24'h000280, "release key state");
    check(change_out === 1'b0, "change output in shift mode");
    check(fast_mode === 1'b1, "awake interval not restarted");
    wrap_up();
  end
endmodule : tb_top
bind tmsc_scan_ctrl tmsc_scan_ctrl_sva u_tmsc_scan_ctrl_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .burst(burst),
  .change_out(change_out), .fast_mode(fast_mode));
